// *** inc/sftic_map.vh ***
// What this block does
// - async mode with stop length clear sends one high stop bit per character
// - async mode with stop length set sends two high stop bits per character
// - receiver checks only the first stop bit whatever stop length says
// - low second stop position is taken as the next start bit
// - sync mode ignores stop length and sends no stop bits
// - format register bit 2 always reads zero; software writes zero
// - prescale select feeds bit timing from clock divided 1, 4, 16, 64
// - control register is 16 bits, always read and write, zero after reset
// - control bits 15 to 8 always read zero; software writes zeros
// - control bit 7 gates the transmit fifo low interrupt request
// - transmit fifo feeds the transmit shift register one character at a time
// - fifo count below transmit trigger sets low flag and requests interrupt
// - request clears after fifo refilled to trigger or above and flag read one then cleared
// - clearing the interrupt enable withdraws a pending low request on tx_fifo_low_irq; the low event bit on irq stays until written one
// - format bit 7 selects async framing (0) or clocked sync (1)
`ifndef SFTIC_MAP_VH
`define SFTIC_MAP_VH
// register word addresses
`define SFTIC_A_FMT 4'h0
`define SFTIC_A_CTL 4'h1
`define SFTIC_A_STS 4'h2
`define SFTIC_A_TXD 4'h3
`define SFTIC_A_BRR 4'h4
`define SFTIC_A_TRG 4'h5
`define SFTIC_A_IST 4'h6
`define SFTIC_A_IMK 4'h7
`define SFTIC_A_RXD 4'h8
// format register fields
`define SFTIC_FMT_SYNC 7
`define SFTIC_FMT_STOP 3
`define SFTIC_FMT_CKS 1:0
`define SFTIC_FMT_WMASK 8'h8B
// control register fields
`define SFTIC_CTL_TIE 7
`define SFTIC_CTL_TE 5
`define SFTIC_CTL_RE 4
// status register fields
`define SFTIC_STS_TX_FIFO_LOW_FLAG 5
// interrupt status bits
`define SFTIC_IS_TXLOW 0
`define SFTIC_IS_RXDONE 1
`define SFTIC_IS_FERR 2
// prescaler terminal counts for 1, 4, 16, 64
`define SFTIC_DIV1 6'h00
`define SFTIC_DIV4 6'h03
`define SFTIC_DIV16 6'h0F
`define SFTIC_DIV64 6'h3F
// reset values
// control keeps only its low byte; the upper byte always reads zero
`define SFTIC_RST_CTL 8'h00
`define SFTIC_RST_FMT 8'h00
`define SFTIC_RST_BRR 8'hFF
`define SFTIC_RST_TRG 5'h01
`endif

// *** rtl/sftic_top.v ***
`timescale 1ns/1ps
`default_nettype none
`include "sftic_map.vh"

module sftic_top #(
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clock,
    input wire rst_n,
    input wire [3:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    input wire rxd_pin,
    output reg txd_pin,
    output reg sck_pin,
    output wire tx_fifo_low_irq,
    output wire irq
);

    localparam TX_IDLE = 2'b00;
    localparam TX_START = 2'b01;
    localparam TX_DATA = 2'b10;
    localparam TX_STOP = 2'b11;
    localparam RX_IDLE = 2'b00;
    localparam RX_START = 2'b01;
    localparam RX_DATA = 2'b10;
    localparam RX_STOP = 2'b11;

    reg [7:0] fmt_q;
    reg [7:0] ctl_q;
    reg [7:0] brr_q;
    reg [4:0] trg_q;
    reg [2:0] ist_q;
    reg [2:0] imk_q;
    reg tx_fifo_low_flag_q;
    reg tx_fifo_low_flag_seen_q;
    reg [7:0] rxd_q;

    reg [7:0] mem [0:DEPTH-1];
    reg [AW-1:0] wp_q;
    reg [AW-1:0] rp_q;
    reg [AW:0] cnt_q;

    reg [5:0] pre_q;
    reg pre_tick;
    reg [5:0] pre_top;
    reg [5:0] tx_pre_q;
    wire tx_tick = tx_pre_q >= pre_top;

    reg [1:0] tx_st_q;
    reg [7:0] tx_sh_q;
    reg [2:0] tx_bit_q;
    reg [7:0] tx_cnt_q;
    reg tx_stop2_q;

    reg rx_s1_q;
    reg rx_s2_q;
    reg [1:0] rx_st_q;
    reg [7:0] rx_sh_q;
    reg [2:0] rx_bit_q;
    reg [7:0] rx_cnt_q;

    wire sync_mode = fmt_q[`SFTIC_FMT_SYNC];
    wire wr_txd = reg_wr && reg_addr == `SFTIC_A_TXD;
    wire fifo_full = cnt_q == DEPTH;
    wire fifo_empty = cnt_q == 0;
    wire push = wr_txd && !fifo_full;
    wire tx_bit_end = tx_tick && tx_cnt_q == brr_q;
    wire tx_load = tx_st_q == TX_IDLE && ctl_q[`SFTIC_CTL_TE] && !fifo_empty;
    wire pop = tx_load;
    wire below_trg = {5'h00, cnt_q} < {{(AW+1){1'b0}}, trg_q};
    wire tx_fifo_low_flag_clr;
    wire rx_done;
    wire rx_ferr;
    wire tx_fifo_low_flag_rise = below_trg && !tx_fifo_low_flag_q;

    // prescaler terminal count from the clock select field
    always @* begin
        case (fmt_q[`SFTIC_FMT_CKS])
            2'b00: pre_top = `SFTIC_DIV1;
            2'b01: pre_top = `SFTIC_DIV4;
            2'b10: pre_top = `SFTIC_DIV16;
            default: pre_top = `SFTIC_DIV64;
        endcase
    end

    // free running prescaler; only the receiver counts its ticks, the transmitter has its own bit timer
    always @(posedge clock) begin
        if (!rst_n) begin
            pre_q <= 6'h00;
            pre_tick <= 1'b0;
        end else if (pre_q >= pre_top) begin
            pre_q <= 6'h00;
            pre_tick <= 1'b1;
        end else begin
            pre_q <= pre_q + 6'h01;
            pre_tick <= 1'b0;
        end
    end

    // transmit bit timer restarts at each load, so the first bit is never short
    always @(posedge clock) begin
        if (!rst_n) begin
            tx_pre_q <= 6'h00;
        end else if (tx_load || tx_tick) begin
            tx_pre_q <= 6'h00;
        end else begin
            tx_pre_q <= tx_pre_q + 6'h01;
        end
    end

    // control and format registers; reserved bits never store
    always @(posedge clock) begin
        if (!rst_n) begin
            ctl_q <= `SFTIC_RST_CTL;
            fmt_q <= `SFTIC_RST_FMT;
            brr_q <= `SFTIC_RST_BRR;
            trg_q <= `SFTIC_RST_TRG;
            imk_q <= 3'h0;
        end else if (reg_wr) begin
            if (reg_addr == `SFTIC_A_CTL) begin
                ctl_q <= reg_wdata[7:0];
            end else if (reg_addr == `SFTIC_A_FMT) begin
                fmt_q <= reg_wdata[7:0] & `SFTIC_FMT_WMASK;
            end else if (reg_addr == `SFTIC_A_BRR) begin
                brr_q <= reg_wdata[7:0];
            end else if (reg_addr == `SFTIC_A_TRG) begin
                trg_q <= reg_wdata[4:0];
            end else if (reg_addr == `SFTIC_A_IMK) begin
                imk_q <= reg_wdata[2:0];
            end
        end
    end

    // transmit fifo storage; writes when full are dropped
    always @(posedge clock) begin
        if (push) begin
            mem[wp_q] <= reg_wdata[7:0];
        end
    end

    // fifo pointers and fill count
    always @(posedge clock) begin
        if (!rst_n) begin
            wp_q <= {AW{1'b0}};
            rp_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wp_q <= wp_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rp_q <= rp_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
            end else if (pop && !push) begin
                cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
            end
        end
    end

    // clear needs a zero write after a read of one and a refilled fifo
    assign tx_fifo_low_flag_clr = reg_wr && reg_addr == `SFTIC_A_STS && !reg_wdata[`SFTIC_STS_TX_FIFO_LOW_FLAG]
        && tx_fifo_low_flag_seen_q && !below_trg;

    // low flag: set wins over clear while the fifo is still under trigger
    always @(posedge clock) begin
        if (!rst_n) begin
            tx_fifo_low_flag_q <= 1'b0;
            tx_fifo_low_flag_seen_q <= 1'b0;
        end else begin
            if (below_trg) begin
                tx_fifo_low_flag_q <= 1'b1;
            end else if (tx_fifo_low_flag_clr) begin
                tx_fifo_low_flag_q <= 1'b0;
            end
            if (tx_fifo_low_flag_clr || !tx_fifo_low_flag_q) begin
                tx_fifo_low_flag_seen_q <= 1'b0;
            end else if (reg_rd && reg_addr == `SFTIC_A_STS) begin
                tx_fifo_low_flag_seen_q <= 1'b1;
            end
        end
    end

    // request follows flag and enable; clearing the enable drops it at once
    assign tx_fifo_low_irq = tx_fifo_low_flag_q && ctl_q[`SFTIC_CTL_TIE];

    // transmitter: one character from the fifo into the shift register
    always @(posedge clock) begin
        if (!rst_n) begin
            tx_st_q <= TX_IDLE;
            tx_sh_q <= 8'h00;
            tx_bit_q <= 3'h0;
            tx_cnt_q <= 8'h00;
            tx_stop2_q <= 1'b0;
            txd_pin <= 1'b1;
        end else begin
            if (tx_bit_end || tx_load) begin
                tx_cnt_q <= 8'h00;
            end else if (tx_tick) begin
                tx_cnt_q <= tx_cnt_q + 8'h01;
            end
            case (tx_st_q)
                TX_IDLE: begin
                    txd_pin <= 1'b1;
                    if (tx_load) begin
                        tx_sh_q <= mem[rp_q];
                        tx_bit_q <= 3'h0;
                        tx_stop2_q <= fmt_q[`SFTIC_FMT_STOP];
                        if (sync_mode) begin
                            tx_st_q <= TX_DATA;
                            txd_pin <= mem[rp_q][0];
                        end else begin
                            tx_st_q <= TX_START;
                            txd_pin <= 1'b0;
                        end
                    end
                end
                TX_START: begin
                    if (tx_bit_end) begin
                        tx_st_q <= TX_DATA;
                        txd_pin <= tx_sh_q[0];
                    end
                end
                TX_DATA: begin
                    if (tx_bit_end) begin
                        tx_sh_q <= {1'b0, tx_sh_q[7:1]};
                        tx_bit_q <= tx_bit_q + 3'h1;
                        if (tx_bit_q != 3'h7) begin
                            txd_pin <= tx_sh_q[1];
                        end else if (sync_mode) begin
                            tx_st_q <= TX_IDLE;
                            txd_pin <= 1'b1;
                        end else begin
                            tx_st_q <= TX_STOP;
                            txd_pin <= 1'b1;
                        end
                    end
                end
                default: begin
                    txd_pin <= 1'b1;
                    if (tx_bit_end) begin
                        if (tx_stop2_q) begin
                            tx_stop2_q <= 1'b0;
                        end else begin
                            tx_st_q <= TX_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // sync clock: low in the first half of each data bit when brr_q is 2 or more, else stays high; idles high
    always @(posedge clock) begin
        if (!rst_n) begin
            sck_pin <= 1'b1;
        end else begin
            sck_pin <= !(sync_mode && tx_st_q == TX_DATA && tx_cnt_q < {1'b0, brr_q[7:1]});
        end
    end

    // two flops before the receive line is looked at
    always @(posedge clock) begin
        if (!rst_n) begin
            rx_s1_q <= 1'b1;
            rx_s2_q <= 1'b1;
        end else begin
            rx_s1_q <= rxd_pin;
            rx_s2_q <= rx_s1_q;
        end
    end

    wire rx_half = pre_tick && rx_cnt_q == {1'b0, brr_q[7:1]};
    wire rx_full = pre_tick && rx_cnt_q == brr_q;

    assign rx_done = rx_st_q == RX_STOP && rx_full && rx_s2_q;
    assign rx_ferr = rx_st_q == RX_STOP && rx_full && !rx_s2_q;

    // async receiver; only the first stop bit is checked and the next low
    // level in idle starts a character, so a low second stop is a start bit
    // it shares the free running prescaler, so at slow prescale settings its
    // sampling point may sit up to one prescale period early
    always @(posedge clock) begin
        if (!rst_n) begin
            rx_st_q <= RX_IDLE;
            rx_sh_q <= 8'h00;
            rx_bit_q <= 3'h0;
            rx_cnt_q <= 8'h00;
            rxd_q <= 8'h00;
        end else begin
            if (rx_st_q == RX_IDLE || rx_full || (rx_st_q == RX_START && rx_half)) begin
                rx_cnt_q <= 8'h00;
            end else if (pre_tick) begin
                rx_cnt_q <= rx_cnt_q + 8'h01;
            end
            case (rx_st_q)
                RX_IDLE: begin
                    if (ctl_q[`SFTIC_CTL_RE] && !sync_mode && !rx_s2_q) begin
                        rx_st_q <= RX_START;
                    end
                end
                RX_START: begin
                    if (rx_half) begin
                        rx_bit_q <= 3'h0;
                        rx_st_q <= rx_s2_q ? RX_IDLE : RX_DATA; // glitch filter
                    end
                end
                RX_DATA: begin
                    if (rx_full) begin
                        rx_sh_q <= {rx_s2_q, rx_sh_q[7:1]};
                        rx_bit_q <= rx_bit_q + 3'h1;
                        if (rx_bit_q == 3'h7) begin
                            rx_st_q <= RX_STOP;
                        end
                    end
                end
                default: begin
                    if (rx_full) begin
                        rxd_q <= rx_sh_q;
                        rx_st_q <= RX_IDLE;
                    end
                end
            endcase
        end
    end

    // sticky event bits, write one to clear; a new event wins over the clear
    always @(posedge clock) begin
        if (!rst_n) begin
            ist_q <= 3'h0;
        end else begin
            if (reg_wr && reg_addr == `SFTIC_A_IST) begin
                ist_q <= (ist_q & ~reg_wdata[2:0]) | {rx_ferr, rx_done, tx_fifo_low_flag_rise};
            end else begin
                ist_q <= ist_q | {rx_ferr, rx_done, tx_fifo_low_flag_rise};
            end
        end
    end

    assign irq = |(ist_q & imk_q);

    // read data in the cycle after the strobe; unmapped words read zero
    always @(posedge clock) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
        end else if (!reg_rd) begin
            reg_rdata <= 16'h0000;
        end else if (reg_addr == `SFTIC_A_FMT) begin
            reg_rdata <= {8'h00, fmt_q};
        end else if (reg_addr == `SFTIC_A_CTL) begin
            reg_rdata <= {8'h00, ctl_q};
        end else if (reg_addr == `SFTIC_A_STS) begin
            reg_rdata <= {{(9-AW){1'b0}}, cnt_q, tx_fifo_low_flag_q, 5'h00}; // fill count above flag
        end else if (reg_addr == `SFTIC_A_BRR) begin
            reg_rdata <= {8'h00, brr_q};
        end else if (reg_addr == `SFTIC_A_TRG) begin
            reg_rdata <= {11'h000, trg_q};
        end else if (reg_addr == `SFTIC_A_IST) begin
            reg_rdata <= {13'h0000, ist_q};
        end else if (reg_addr == `SFTIC_A_IMK) begin
            reg_rdata <= {13'h0000, imk_q};
        end else if (reg_addr == `SFTIC_A_RXD) begin
            reg_rdata <= {8'h00, rxd_q};
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

endmodule // sftic_top
`default_nettype wire

// *** dv/sftic_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sftic_map.vh"
module sftic_checker (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic rxd_pin,
    input wire logic txd_pin,
    input wire logic sck_pin,
    input wire logic tx_fifo_low_irq,
    input wire logic irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic tie_q;
    logic sync_q;
    // shadow of enable and mode bits, since the checker sees only the ports
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            tie_q <= 1'b0;
            sync_q <= 1'b0;
        end else if (reg_wr && reg_addr == `SFTIC_A_CTL) begin
            tie_q <= reg_wdata[7];
        end else if (reg_wr && reg_addr == `SFTIC_A_FMT) begin
            sync_q <= reg_wdata[7];
        end
    end
    property p_irq_gate;
        !tie_q |-> !tx_fifo_low_irq;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("low irq with enable clear");
    property p_irq_drop;
        reg_wr && reg_addr == `SFTIC_A_CTL && !reg_wdata[7] |=> !tx_fifo_low_irq [*2];
    endproperty
    a_irq_drop: assert property (p_irq_drop) else $error("low irq not withdrawn");
    property p_ctl_hi;
        reg_rd && reg_addr == `SFTIC_A_CTL |=> reg_rdata[15:8] == 8'h00;
    endproperty
    a_ctl_hi: assert property (p_ctl_hi) else $error("control upper byte not zero");
    property p_fmt_b2;
        reg_rd && reg_addr == `SFTIC_A_FMT |=> reg_rdata[2] == 1'b0;
    endproperty
    a_fmt_b2: assert property (p_fmt_b2) else $error("format bit 2 not zero");
    property p_ctl_rw;
        reg_wr && reg_addr == `SFTIC_A_CTL ##2 reg_rd && reg_addr == `SFTIC_A_CTL
            |=> reg_rdata == ($past(reg_wdata, 3) & 16'h00FF);
    endproperty
    a_ctl_rw: assert property (p_ctl_rw) else $error("control readback wrong");
    property p_fmt_rw;
        reg_wr && reg_addr == `SFTIC_A_FMT ##2 reg_rd && reg_addr == `SFTIC_A_FMT
            |=> reg_rdata == ($past(reg_wdata, 3) & 16'h008B);
    endproperty
    a_fmt_rw: assert property (p_fmt_rw) else $error("format readback wrong");
    property p_rd_idle;
        !reg_rd |=> reg_rdata == 16'h0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle");
    property p_sck_async;
        !sync_q |-> sck_pin;
    endproperty
    a_sck_async: assert property (p_sck_async) else $error("bit clock moved in async");
    c_low_irq: cover property ($rose(tx_fifo_low_irq));
    c_sync: cover property (sync_q && !sck_pin);
    c_irq: cover property ($rose(irq));
endmodule // sftic_checker
bind sftic_top sftic_checker u_chk (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rxd_pin(rxd_pin), .txd_pin(txd_pin), .sck_pin(sck_pin),
    .tx_fifo_low_irq(tx_fifo_low_irq), .irq(irq));
`default_nettype wire

// *** dv/sftic_peer.sv ***
`timescale 1ns/1ps
`default_nettype none
module sftic_peer (
    input wire logic clock,
    output var logic rxd_pin
);
    initial rxd_pin = 1'b1;
    // start, eight bits lsb first, one stop at the given level; a low stop is
    // followed by a mark bit so the line never stays stuck low
    task automatic send(input logic [7:0] d, input logic stop_lvl, input int bt);
        logic [9:0] f;
        f = {stop_lvl, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxd_pin <= f[i];
            repeat (bt) @(posedge clock);
        end
        if (!stop_lvl) begin
            rxd_pin <= 1'b1;
            repeat (bt) @(posedge clock);
        end
    endtask
endmodule // sftic_peer
`default_nettype wire

// *** dv/sftic_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sftic_map.vh"
module sftic_tb;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    wire [15:0] reg_rdata;
    wire rxd_pin, txd_pin, sck_pin, tx_fifo_low_irq, irq;
    int miscompares = 0;
    int checked = 0;
    logic [15:0] rv;
    always #5 clock = ~clock;
    sftic_top dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rxd_pin(rxd_pin),
        .txd_pin(txd_pin), .sck_pin(sck_pin), .tx_fifo_low_irq(tx_fifo_low_irq), .irq(irq));
    sftic_peer peer (.clock(clock), .rxd_pin(rxd_pin));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic fail_out;
        miscompares++;
        results;
    endtask
    // bus tasks start and end on a rising edge
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
        // one idle edge, so a following write never re-raises the strobe in this step
        @(posedge clock);
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        d = reg_rdata;
        @(posedge clock);
    endtask
    task automatic rchk(input logic [3:0] a, input logic [15:0] e);
        rd(a, rv);
        chk(rv, e);
    endtask
    // both interrupt outputs, looked at mid-cycle once the edge has settled
    task automatic pins(input logic [1:0] e);
        @(negedge clock);
        chk({14'h0000, tx_fifo_low_irq, irq}, {14'h0000, e});
        @(posedge clock);
    endtask
    task automatic reg_test;
        rchk(`SFTIC_A_CTL, 16'h0000);
        wr(`SFTIC_A_CTL, 16'hFFFF);
        rchk(`SFTIC_A_CTL, 16'h00FF);
        wr(`SFTIC_A_FMT, 16'hFFFF);
        rchk(`SFTIC_A_FMT, 16'h008B);
        wr(4'hF, 16'hFFFF);
        rchk(4'hF, 16'h0000);
        wr(`SFTIC_A_CTL, 16'h0000);
        wr(`SFTIC_A_FMT, 16'h0000);
    endtask
    task automatic irq_flow;
        int n;
        pins(2'b00);
        wr(`SFTIC_A_BRR, 16'h0000);
        wr(`SFTIC_A_IMK, 16'h0001);
        pins(2'b01);
        wr(`SFTIC_A_CTL, 16'h0080);
        pins(2'b11);
        wr(`SFTIC_A_TXD, 16'h0011);
        wr(`SFTIC_A_TXD, 16'h0022);
        rd(`SFTIC_A_STS, rv);
        chk(rv & 16'h0020, 16'h0020);
        wr(`SFTIC_A_STS, 16'h0000);
        pins(2'b01);
        wr(`SFTIC_A_IST, 16'h0001);
        pins(2'b00);
        // transmitter drains the two characters; flag returns when count drops below one
        wr(`SFTIC_A_CTL, 16'h00A0);
        n = 0;
        while (tx_fifo_low_irq !== 1'b1 && n < 400) begin
            @(negedge clock);
            n++;
        end
        if (n == 400) fail_out;
        @(posedge clock);
        wr(`SFTIC_A_CTL, 16'h0020);
        pins(2'b01);
        wr(`SFTIC_A_IMK, 16'h0000);
        pins(2'b00);
        repeat (20) @(posedge clock);
    endtask
    // two characters queued: the next start follows the stop bits after one idle clock
    task automatic tx_frame(input logic [7:0] d, input int bt, input int nstop);
        int n;
        logic e;
        wr(`SFTIC_A_CTL, 16'h0010);
        wr(`SFTIC_A_TXD, {8'h00, d});
        wr(`SFTIC_A_TXD, 16'h00FF);
        // enable last, so the start edge lands right after the task returns
        wr(`SFTIC_A_CTL, 16'h0030);
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (txd_pin !== 1'b0 && n < 400);
        if (n == 400) fail_out;
        for (int i = 0; i <= 9 + nstop; i++) begin
            repeat ((i == 0 ? bt / 2 : bt) + (i == 9 + nstop ? 1 : 0)) @(negedge clock);
            e = (i == 0) ? 1'b0 : (i <= 8) ? d[i-1] : (i < 9 + nstop) ? 1'b1 : 1'b0;
            chk({15'h0000, txd_pin}, {15'h0000, e});
        end
        repeat ((11 + nstop) * bt) @(posedge clock);
    endtask
    task automatic sync_tx;
        int n, r, f, l;
        logic p;
        logic [15:0] bits;
        wr(`SFTIC_A_CTL, 16'h0010);
        wr(`SFTIC_A_FMT, 16'h0088);
        wr(`SFTIC_A_BRR, 16'h0003);
        wr(`SFTIC_A_TXD, 16'h00A5);
        wr(`SFTIC_A_TXD, 16'h003C);
        wr(`SFTIC_A_CTL, 16'h0030);
        n = 0;
        r = 0;
        p = 1'b1;
        // a bit is taken at each rise of the bit clock, mid bit
        while (r < 16 && n < 400) begin
            @(negedge clock);
            n++;
            if (!p && sck_pin) begin
                bits[r] = txd_pin;
                if (r == 0) f = n;
                l = n;
                r++;
            end
            p = sck_pin;
        end
        if (n == 400) fail_out;
        chk(bits, 16'h3CA5);
        // fifteen bit times plus the one idle clock before the second load
        chk(16'(l - f), 16'h003D);
        repeat (8) @(posedge clock);
        wr(`SFTIC_A_FMT, 16'h0000);
    endtask
    task automatic rx_chain;
        wr(`SFTIC_A_FMT, 16'h0008);
        wr(`SFTIC_A_BRR, 16'h0007);
        wr(`SFTIC_A_IST, 16'h0007);
        peer.send(8'hA5, 1'b1, 8);
        peer.send(8'h3C, 1'b1, 8);
        repeat (16) @(posedge clock);
        rd(`SFTIC_A_IST, rv);
        chk(rv & 16'h0006, 16'h0002);
        rchk(`SFTIC_A_RXD, 16'h003C);
        wr(`SFTIC_A_IST, 16'h0007);
        peer.send(8'h5A, 1'b0, 8);
        repeat (16) @(posedge clock);
        rd(`SFTIC_A_IST, rv);
        chk(rv & 16'h0004, 16'h0004);
    endtask
    task automatic results;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        reg_test;
        irq_flow;
        wr(`SFTIC_A_CTL, 16'h0030);
        for (int ps = 0; ps < 4; ps++) begin
            wr(`SFTIC_A_FMT, {14'h0000, ps[1:0]});
            tx_frame(8'h5A, 1 << (2 * ps), 1);
        end
        wr(`SFTIC_A_FMT, 16'h0009);
        tx_frame(8'hC3, 4, 2);
        sync_tx;
        rx_chain;
        results;
    end
endmodule // sftic_tb
`default_nettype wire
